/* File: rtl/bdto_queue.sv */
`timescale 1ns/1ns
`include "bdto_consts.svh"

// One direction of the bridge: ordered slots, pass decisions, retire
module bdto_queue #(
  parameter int DEPTH = 4,
  parameter int DISCARD_CLKS = `BDTO_DISCARD_CLKS
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Originating side attempt
  input wire logic orig_valid_in,
  input wire bdto_pkg::bdto_req_t orig_req_in,
  output logic orig_retry_out,
  output logic orig_done_out,
  output bdto_pkg::bdto_res_t orig_res_out,
  // Destination side master
  output logic dest_valid_out,
  output bdto_pkg::bdto_req_t dest_req_out,
  input wire logic dest_done_in,
  input wire logic dest_retry_in,
  input wire bdto_pkg::bdto_res_t dest_res_in,
  // Opposite queue holds a posted write of any age
  input wire logic opp_pmw_in,
  output logic pmw_pending_out,
  input wire logic drop_req_in,
  output logic discard_out
);
  import bdto_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(DISCARD_CLKS + 1);

  bdto_entry_t slot_r [DEPTH];
  bdto_entry_t slot_nxt [DEPTH];
  logic [AW:0] age_r [DEPTH];
  logic [AW:0] age_nxt [DEPTH];
  logic [TW-1:0] tmr_r [DEPTH];
  logic [TW-1:0] tmr_nxt [DEPTH];
  logic [AW:0] cur_r, cur_nxt;
  logic [2:0] fair_r, fair_nxt;
  logic cur_act_r, cur_act_nxt;
  bdto_kind_t in_kind;

  bdto_classify u_cls (
    .cmd_in(orig_req_in.cmd),
    .kind_out(in_kind)
  );

  // Same request repeated by the master
  function automatic logic same_req(input bdto_req_t a, input bdto_req_t b);
    same_req = (a.cmd == b.cmd) && (a.addr == b.addr) && (a.be == b.be)
      && ((a.cmd[0] == 1'b0) || (a.data == b.data));
  endfunction

  // True when slot j holds a posted write older than slot i
  function automatic logic older_pmw(input int i, input int j);
    older_pmw = slot_r[j].valid && slot_r[j].kind == BDTO_PMW
      && age_r[j] < age_r[i];
  endfunction

  // ----------------------------------------
  // Queue state update
  // ----------------------------------------
  always_comb begin
    logic hit;
    logic placed;
    logic blocked;
    logic found;
    logic pmw_wait;
    logic [AW:0] pick;
    logic [AW:0] pmw_pick;
    logic [AW:0] oldest;
    hit = 1'b0;
    placed = 1'b0;
    found = 1'b0;
    pmw_wait = 1'b0;
    pick = '0;
    pmw_pick = '0;
    oldest = '1;
    blocked = 1'b0;
    cur_nxt = cur_r;
    fair_nxt = fair_r;
    cur_act_nxt = cur_act_r;
    orig_retry_out = 1'b0;
    orig_done_out = 1'b0;
    orig_res_out = '0;
    discard_out = 1'b0;
    pmw_pending_out = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      slot_nxt[i] = slot_r[i];
      age_nxt[i] = age_r[i];
      tmr_nxt[i] = tmr_r[i];
      if (slot_r[i].valid && slot_r[i].kind == BDTO_PMW) pmw_pending_out = 1'b1;
    end
    // Repeat of an earlier request: retire or keep retrying
    for (int i = 0; i < DEPTH; i++) begin
      if (orig_valid_in && slot_r[i].valid && same_req(slot_r[i].req, orig_req_in)
          && slot_r[i].kind != BDTO_PMW) begin
        hit = 1'b1;
        blocked = 1'b0;
        for (int j = 0; j < DEPTH; j++) begin
          if (older_pmw(i, j) && slot_r[i].kind == BDTO_DRC) blocked = 1'b1;
        end
        if (slot_r[i].kind == BDTO_DRC && opp_pmw_in) blocked = 1'b1;
        if ((slot_r[i].kind == BDTO_DRC || slot_r[i].kind == BDTO_DWC) && !blocked) begin
          orig_done_out = 1'b1;
          orig_res_out = slot_r[i].res;
          slot_nxt[i].valid = 1'b0;
        end else begin
          orig_retry_out = 1'b1;
        end
      end
    end
    // First attempt: latch and answer Retry, posted write accepted
    if (orig_valid_in && !hit) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !slot_r[i].valid && in_kind != BDTO_NONE) begin
          placed = 1'b1;
          slot_nxt[i].valid = 1'b1;
          slot_nxt[i].kind = in_kind;
          slot_nxt[i].req = orig_req_in;
          slot_nxt[i].res = '0;
          slot_nxt[i].tried = 1'b0;
          slot_nxt[i].toward_orig = 1'b0;
          age_nxt[i] = '1;
          tmr_nxt[i] = '0;
        end
      end
      // Memory writes need a free slot only, never a drained request
      if (in_kind == BDTO_PMW && placed) orig_done_out = 1'b1;
      else orig_retry_out = 1'b1;
      // Drop an untried request to make room for a posted write
      if (in_kind == BDTO_PMW && !placed) begin
        for (int i = 0; i < DEPTH; i++) begin
          if (!found && slot_r[i].valid && !slot_r[i].tried
              && (slot_r[i].kind == BDTO_DRR || slot_r[i].kind == BDTO_DWR)) begin
            found = 1'b1;
            slot_nxt[i].valid = 1'b0;
          end
        end
      end
    end
    // Software-free drop of untried requests on demand
    if (drop_req_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (slot_r[i].valid && !slot_r[i].tried
            && (slot_r[i].kind == BDTO_DRR || slot_r[i].kind == BDTO_DWR))
          slot_nxt[i].valid = 1'b0;
      end
    end
    // Discard timer for delayed read and write completions
    for (int i = 0; i < DEPTH; i++) begin
      if (slot_r[i].valid && (slot_r[i].kind == BDTO_DRC || slot_r[i].kind == BDTO_DWC)) begin
        tmr_nxt[i] = tmr_r[i] + 1'b1;
        if (tmr_r[i] == TW'(DISCARD_CLKS - 1)) begin
          slot_nxt[i].valid = 1'b0;
          discard_out = 1'b1;
        end
      end
    end
    // Destination choice: oldest eligible request, posted writes in order
    found = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      if (slot_r[i].valid && slot_r[i].kind == BDTO_PMW
          && (!pmw_wait || age_r[i] < oldest)) begin
        oldest = age_r[i];
        pmw_pick = (AW+1)'(i);
        pmw_wait = 1'b1;
      end
    end
    oldest = '1;
    for (int i = 0; i < DEPTH; i++) begin
      blocked = 1'b0;
      for (int j = 0; j < DEPTH; j++) begin
        if (older_pmw(i, j)) blocked = 1'b1;
      end
      // A request dropped in this cycle is never started
      if (slot_r[i].valid && slot_nxt[i].valid && !blocked && (!found || age_r[i] < oldest)
          && (slot_r[i].kind == BDTO_DRR || slot_r[i].kind == BDTO_DWR)) begin
        oldest = age_r[i];
        pick = (AW+1)'(i);
        found = 1'b1;
      end
    end
    // Older delayed requests go first; posted writes pass them once fair_r reaches the fairness cap
    if (!cur_act_r) begin
      if (pmw_wait && (!found || fair_r >= 3'(`BDTO_FAIR_LIMIT))) begin
        cur_nxt = pmw_pick;
        cur_act_nxt = 1'b1;
      end else if (found) begin
        cur_nxt = pick;
        cur_act_nxt = 1'b1;
        slot_nxt[pick[AW-1:0]].tried = 1'b1;
      end
    end
    dest_valid_out = cur_act_r;
    dest_req_out = slot_r[cur_r[AW-1:0]].req;
    if (cur_act_r) begin
      slot_nxt[cur_r[AW-1:0]].tried = 1'b1;
      if (dest_done_in) begin
        cur_act_nxt = 1'b0;
        if (slot_r[cur_r[AW-1:0]].kind == BDTO_PMW) begin
          slot_nxt[cur_r[AW-1:0]].valid = 1'b0;
          fair_nxt = '0;
        end else begin
          slot_nxt[cur_r[AW-1:0]].kind = (slot_r[cur_r[AW-1:0]].kind == BDTO_DRR)
            ? BDTO_DRC : BDTO_DWC;
          slot_nxt[cur_r[AW-1:0]].res.status = dest_res_in.status;
          slot_nxt[cur_r[AW-1:0]].res.data = (slot_r[cur_r[AW-1:0]].kind == BDTO_DRR)
            ? dest_res_in.data : 32'h0;
          slot_nxt[cur_r[AW-1:0]].toward_orig = 1'b1;
          tmr_nxt[cur_r[AW-1:0]] = '0;
          if (pmw_wait && fair_r != 3'h7) fair_nxt = fair_r + 3'h1;
        end
      end else if (dest_retry_in) begin
        cur_act_nxt = 1'b1;
      end
    end
    // Ageing keeps acceptance order relative
    for (int i = 0; i < DEPTH; i++) begin
      if (slot_r[i].valid && age_r[i] != '0 && placed)
        age_nxt[i] = age_r[i] - 1'b1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_r[i] <= '0;
        age_r[i] <= '1;
        tmr_r[i] <= '0;
      end
      cur_r <= '0;
      fair_r <= '0;
      cur_act_r <= 1'b0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        slot_r[i] <= slot_nxt[i];
        age_r[i] <= age_nxt[i];
        tmr_r[i] <= tmr_nxt[i];
      end
      cur_r <= cur_nxt;
      fair_r <= fair_nxt;
      cur_act_r <= cur_act_nxt;
    end
  end
endmodule

/* File: shared/bdto_consts.svh */
`ifndef BDTO_CONSTS_SVH
`define BDTO_CONSTS_SVH

// ----------------------------------------
// Command codes of the originating bus
// ----------------------------------------
`define BDTO_CMD_IO_RD 4'h2
`define BDTO_CMD_IO_WR 4'h3
`define BDTO_CMD_MEM_RD 4'h6
`define BDTO_CMD_MEM_WR 4'h7
`define BDTO_CMD_CFG_RD 4'hA
`define BDTO_CMD_CFG_WR 4'hB
`define BDTO_CMD_MEM_RD_MUL 4'hC
`define BDTO_CMD_MEM_RD_LINE 4'hE
`define BDTO_CMD_MEM_WR_INV 4'hF

// ----------------------------------------
// Completion status codes
// ----------------------------------------
`define BDTO_ST_NORMAL 2'h0
`define BDTO_ST_MABORT 2'h1
`define BDTO_ST_TABORT 2'h2
`define BDTO_ST_PERR 2'h3

// ----------------------------------------
// Timing
// ----------------------------------------
`define BDTO_DISCARD_CLKS 32768
`define BDTO_FAIR_LIMIT 4

`endif

/* File: shared/bdto_pkg.sv */
package bdto_pkg;

  // Entry class held in a direction queue
  typedef enum logic [2:0] {
    BDTO_NONE = 3'b000,
    BDTO_PMW = 3'b001,
    BDTO_DRR = 3'b010,
    BDTO_DWR = 3'b011,
    BDTO_DRC = 3'b100,
    BDTO_DWC = 3'b101
  } bdto_kind_t;

  // Request as seen on an originating bus
  typedef struct packed {
    logic [3:0] cmd;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
    logic pref;
  } bdto_req_t;

  // Result of a destination bus attempt
  typedef struct packed {
    logic [1:0] status;
    logic [31:0] data;
  } bdto_res_t;

  // One queue slot
  typedef struct packed {
    logic valid;
    bdto_kind_t kind;
    bdto_req_t req;
    bdto_res_t res;
    logic tried;
    logic toward_orig;
  } bdto_entry_t;

endpackage

/* File: rtl/bdto_classify.sv */
`timescale 1ns/1ns
`include "bdto_consts.svh"

// Command classifier: posted write, delayed read or delayed write
module bdto_classify (
  input wire logic [3:0] cmd_in,
  output bdto_pkg::bdto_kind_t kind_out
);
  import bdto_pkg::*;

  // ----------------------------------------
  // Classification
  // ----------------------------------------
  always_comb begin
    case (cmd_in)
      `BDTO_CMD_MEM_WR, `BDTO_CMD_MEM_WR_INV: kind_out = BDTO_PMW;
      `BDTO_CMD_IO_RD, `BDTO_CMD_CFG_RD, `BDTO_CMD_MEM_RD,
      `BDTO_CMD_MEM_RD_LINE, `BDTO_CMD_MEM_RD_MUL: kind_out = BDTO_DRR;
      `BDTO_CMD_IO_WR, `BDTO_CMD_CFG_WR: kind_out = BDTO_DWR;
      default: kind_out = BDTO_NONE;
    endcase
  end
endmodule

/* File: rtl/bdto_bridge.sv */
`timescale 1ns/1ns
`include "bdto_consts.svh"


// Two-direction delayed transaction bridge core
module bdto_bridge #(
  parameter int DEPTH = 4,
  parameter int DISCARD_CLKS = `BDTO_DISCARD_CLKS
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Primary bus target side
  input wire logic pri_valid_in,
  input wire bdto_pkg::bdto_req_t pri_req_in,
  output logic pri_retry_out,
  output logic pri_done_out,
  output bdto_pkg::bdto_res_t pri_res_out,
  // Secondary bus target side
  input wire logic sec_valid_in,
  input wire bdto_pkg::bdto_req_t sec_req_in,
  output logic sec_retry_out,
  output logic sec_done_out,
  output bdto_pkg::bdto_res_t sec_res_out,
  // Master on secondary bus for downstream traffic
  output logic down_valid_out,
  output bdto_pkg::bdto_req_t down_req_out,
  input wire logic down_done_in,
  input wire logic down_retry_in,
  input wire bdto_pkg::bdto_res_t down_res_in,
  // Master on primary bus for upstream traffic
  output logic up_valid_out,
  output bdto_pkg::bdto_req_t up_req_out,
  input wire logic up_done_in,
  input wire logic up_retry_in,
  input wire bdto_pkg::bdto_res_t up_res_in,
  // Request drop and discard reporting
  input wire logic drop_req_in,
  output logic discard_out
);
  import bdto_pkg::*;

  logic down_pmw, up_pmw, down_disc, up_disc;

  // ----------------------------------------
  // Downstream queue: primary to secondary
  // ----------------------------------------
  // Read completions here drain after upstream posted writes
  bdto_queue #(
    .DEPTH(DEPTH),
    .DISCARD_CLKS(DISCARD_CLKS)
  ) u_down (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .orig_valid_in(pri_valid_in),
    .orig_req_in(pri_req_in),
    .orig_retry_out(pri_retry_out),
    .orig_done_out(pri_done_out),
    .orig_res_out(pri_res_out),
    .dest_valid_out(down_valid_out),
    .dest_req_out(down_req_out),
    .dest_done_in(down_done_in),
    .dest_retry_in(down_retry_in),
    .dest_res_in(down_res_in),
    .opp_pmw_in(up_pmw),
    .pmw_pending_out(down_pmw),
    .drop_req_in(drop_req_in),
    .discard_out(down_disc)
  );

  // ----------------------------------------
  // Upstream queue: secondary to primary
  // ----------------------------------------
  bdto_queue #(
    .DEPTH(DEPTH),
    .DISCARD_CLKS(DISCARD_CLKS)
  ) u_up (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .orig_valid_in(sec_valid_in),
    .orig_req_in(sec_req_in),
    .orig_retry_out(sec_retry_out),
    .orig_done_out(sec_done_out),
    .orig_res_out(sec_res_out),
    .dest_valid_out(up_valid_out),
    .dest_req_out(up_req_out),
    .dest_done_in(up_done_in),
    .dest_retry_in(up_retry_in),
    .dest_res_in(up_res_in),
    .opp_pmw_in(down_pmw),
    .pmw_pending_out(up_pmw),
    .drop_req_in(drop_req_in),
    .discard_out(up_disc)
  );

  // Discard event from either direction
  assign discard_out = down_disc | up_disc;
endmodule

/* File: verification/bdto_bridge_assertions.sv */
`timescale 1ns/1ns
`include "bdto_consts.svh"

// ----------------------------------------
// Port checks of the bridge core
// ----------------------------------------
module bdto_bridge_assertions #(
  parameter int DEPTH = 4,
  parameter int DISCARD_CLKS = `BDTO_DISCARD_CLKS
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic pri_valid_in,
  input wire bdto_pkg::bdto_req_t pri_req_in,
  input wire logic pri_retry_out,
  input wire logic pri_done_out,
  input wire logic sec_valid_in,
  input wire logic sec_retry_out,
  input wire logic sec_done_out,
  input wire logic down_valid_out,
  input wire bdto_pkg::bdto_req_t down_req_out,
  input wire logic down_done_in,
  input wire logic down_retry_in,
  input wire logic up_valid_out,
  input wire logic up_done_in
);
  import bdto_pkg::*;

  // One clock domain for every check
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_pri_one_answer: assert property (
    pri_valid_in |-> pri_retry_out != pri_done_out)
    else $error("primary attempt needs exactly one answer");
  chk_pri_no_stray: assert property (
    !pri_valid_in |-> !pri_retry_out && !pri_done_out)
    else $error("primary answer without an attempt");
  chk_sec_one_answer: assert property (
    sec_valid_in |-> sec_retry_out != sec_done_out)
    else $error("secondary attempt needs exactly one answer");
  chk_unknown_cmd: assert property (
    pri_valid_in && pri_req_in.cmd == 4'h0 |-> pri_retry_out)
    else $error("unknown command not retried");
  chk_posted_forward: assert property (
    pri_valid_in && pri_done_out && pri_req_in.cmd == `BDTO_CMD_MEM_WR
    |-> ##[1:200] down_valid_out)
    else $error("posted write never forwarded");
  chk_reset_quiet: assert property (
    $fell(sys_rst_in) |-> !down_valid_out && !up_valid_out)
    else $error("master active right after reset");
  chk_down_stays: assert property (
    down_valid_out && !down_done_in |=> down_valid_out)
    else $error("downstream request given up before done");
  chk_down_stable: assert property (
    down_valid_out && !down_done_in && !down_retry_in |=> $stable(down_req_out))
    else $error("downstream request changed while waiting");
  chk_up_stays: assert property (
    up_valid_out && !up_done_in |=> up_valid_out)
    else $error("upstream request given up before done");
endmodule

bind bdto_bridge bdto_bridge_assertions #(.DEPTH(DEPTH), .DISCARD_CLKS(DISCARD_CLKS)) u_chk (
  .sys_clk_in, .sys_rst_in, .pri_valid_in, .pri_req_in, .pri_retry_out, .pri_done_out,
  .sec_valid_in, .sec_retry_out, .sec_done_out, .down_valid_out, .down_req_out,
  .down_done_in, .down_retry_in, .up_valid_out, .up_done_in);

/* File: verification/bdto_target_model.sv */
`timescale 1ns/1ns

// Destination target: answers after a wait, optionally Retry first
module bdto_target_model (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic valid_in,
  input wire bdto_pkg::bdto_req_t req_in,
  input wire logic [3:0] lat_in,
  input wire logic [1:0] nretry_in,
  input wire logic [1:0] status_in,
  output logic done_out,
  output logic retry_out,
  output bdto_pkg::bdto_res_t res_out
);
  import bdto_pkg::*;
  logic [3:0] cnt_r;
  logic [1:0] tries_r;
  bdto_res_t res_r;

  // Result lines show the inverse of the last value outside done
  assign res_out = done_out ? res_r : bdto_res_t'(~res_r);

  // Wait counter, Retry count and one-cycle answers
  always_ff @(posedge sys_clk_in) begin
    done_out <= 1'b0;
    retry_out <= 1'b0;
    if (sys_rst_in) begin
      tries_r <= 2'h0;
      res_r <= '0;
    end
    if (sys_rst_in || !valid_in || done_out || retry_out) begin
      cnt_r <= 4'h0;
    end else if (cnt_r < lat_in) begin
      cnt_r <= cnt_r + 4'h1;
    end else if (tries_r < nretry_in) begin
      retry_out <= 1'b1;
      tries_r <= tries_r + 2'h1;
    end else begin
      done_out <= 1'b1;
      tries_r <= 2'h0;
      res_r <= {status_in, ~req_in.addr};
    end
  end
endmodule

/* File: verification/bdto_bridge_test.sv */
`timescale 1ns/1ns
`include "bdto_consts.svh"

// ----------------------------------------
// Bench for the bridge core
// ----------------------------------------
module bdto_bridge_test;
  import bdto_pkg::*;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic pri_valid_in = 1'b0;
  logic sec_valid_in = 1'b0;
  logic drop_req_in = 1'b0;
  bdto_req_t pri_req_in = '0;
  bdto_req_t sec_req_in = '0;
  bdto_req_t down_req_out, up_req_out;
  bdto_res_t pri_res_out, sec_res_out, down_res_in, up_res_in;
  logic pri_retry_out, pri_done_out, sec_retry_out, sec_done_out, discard_out;
  logic down_valid_out, down_done_in, down_retry_in, up_valid_out, up_done_in, up_retry_in;
  logic [3:0] dlat = 4'h1;
  logic [3:0] ulat = 4'h1;
  logic [1:0] dnr = 2'h0;
  logic [1:0] dst = 2'h0;
  logic [1:0] ust = 2'h0;
  logic [31:0] dlog[$];
  logic [31:0] ulog[$];
  int ulog_at = 0;
  int err_total = 0;
  int n_checks = 0;

  bdto_bridge #(.DEPTH(4), .DISCARD_CLKS(16)) u_dut (
    .sys_clk_in, .sys_rst_in, .pri_valid_in, .pri_req_in, .pri_retry_out, .pri_done_out,
    .pri_res_out, .sec_valid_in, .sec_req_in, .sec_retry_out, .sec_done_out, .sec_res_out,
    .down_valid_out, .down_req_out, .down_done_in, .down_retry_in, .down_res_in,
    .up_valid_out, .up_req_out, .up_done_in, .up_retry_in, .up_res_in,
    .drop_req_in, .discard_out);
  bdto_target_model u_down (.sys_clk_in, .sys_rst_in, .valid_in(down_valid_out),
    .req_in(down_req_out), .lat_in(dlat), .nretry_in(dnr), .status_in(dst),
    .done_out(down_done_in), .retry_out(down_retry_in), .res_out(down_res_in));
  bdto_target_model u_up (.sys_clk_in, .sys_rst_in, .valid_in(up_valid_out),
    .req_in(up_req_out), .lat_in(ulat), .nretry_in(2'h0), .status_in(ust),
    .done_out(up_done_in), .retry_out(up_retry_in), .res_out(up_res_in));

  // Clock and destination completion logs
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    if (down_valid_out && down_done_in) dlog.push_back(down_req_out.addr);
    if (up_valid_out && up_done_in) ulog.push_back(up_req_out.addr);
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One attempt, held for one cycle, answer sampled before the taking edge
  task automatic attempt(input bit pri, input logic [3:0] cmd, input logic [31:0] addr,
      output logic rt, output logic dn, output bdto_res_t rs);
    bdto_req_t r;
    r = '{cmd: cmd, addr: addr, data: addr + 32'h1, be: 4'hF, pref: 1'b0};
    @(negedge sys_clk_in);
    pri_valid_in = pri;
    sec_valid_in = !pri;
    pri_req_in = r;
    sec_req_in = r;
    #4;
    rt = pri ? pri_retry_out : sec_retry_out;
    dn = pri ? pri_done_out : sec_done_out;
    rs = pri ? pri_res_out : sec_res_out;
    if (dn === 1'b1 && pri) ulog_at = ulog.size();
    @(negedge sys_clk_in);
    pri_valid_in = 1'b0;
    sec_valid_in = 1'b0;
    pri_req_in = bdto_req_t'(~r);
    sec_req_in = bdto_req_t'(~r);
  endtask

  // Whole transaction: first answer, repeats until done, result
  task automatic txn(input bit pri, input logic [3:0] cmd, input logic [31:0] addr,
      input bit posted, input logic [1:0] st, input bit rd);
    logic rt, dn;
    bdto_res_t rs;
    attempt(pri, cmd, addr, rt, dn, rs);
    check("first retry", !posted, rt);
    for (int i = 0; i < 80 && dn !== 1'b1; i++) attempt(pri, cmd, addr, rt, dn, rs);
    if (dn !== 1'b1) begin
      err_total++;
      $display("MISMATCH txn done expected 1 seen 0");
      final_report();
    end
    if (!posted) check("status", st, rs.status);
    if (rd) check("read data", ~addr, rs.data);
  endtask

  task automatic s_classify();
    logic [3:0] rds[5] = '{`BDTO_CMD_IO_RD, `BDTO_CMD_CFG_RD, `BDTO_CMD_MEM_RD,
      `BDTO_CMD_MEM_RD_LINE, `BDTO_CMD_MEM_RD_MUL};
    logic rt, dn;
    bdto_res_t rs;
    for (int i = 0; i < 5; i++) begin
      dst = 2'(i);
      txn(1, rds[i], 32'h100 + 32'(i * 16), 0, dst, 1);
    end
    ust = `BDTO_ST_MABORT;
    txn(0, `BDTO_CMD_IO_WR, 32'h200, 0, ust, 0);
    ust = `BDTO_ST_TABORT;
    txn(0, `BDTO_CMD_CFG_WR, 32'h210, 0, ust, 0);
    txn(0, `BDTO_CMD_MEM_WR_INV, 32'h220, 1, 2'h0, 0);
    attempt(1, 4'h0, 32'h230, rt, dn, rs);
    check("unknown cmd retry", 1, rt);
  endtask

  // Posted writes, then a delayed read or write, with downstream Retry
  task automatic s_order();
    dlat = 4'h3;
    dnr = 2'h1;
    for (int k = 0; k < 2; k++) begin
      repeat (20) @(negedge sys_clk_in);
      dlog.delete();
      txn(1, `BDTO_CMD_MEM_WR, 32'hA00, 1, 2'h0, 0);
      txn(1, `BDTO_CMD_MEM_WR_INV, 32'hB00, 1, 2'h0, 0);
      txn(1, k ? `BDTO_CMD_MEM_RD : `BDTO_CMD_IO_WR, 32'hC00, 0, dst, k);
      check("down count", 3, dlog.size());
      check("down first", 32'hA00, dlog[0]);
      check("down second", 32'hB00, dlog[1]);
      check("down last", 32'hC00, dlog[2]);
    end
    dnr = 2'h0;
    dlat = 4'h1;
  endtask

  // Read completion waits for older upstream posted write
  task automatic s_pull();
    ulat = 4'hC;
    ulog.delete();
    txn(0, `BDTO_CMD_MEM_WR, 32'h3000, 1, 2'h0, 0);
    txn(1, `BDTO_CMD_MEM_RD_LINE, 32'h3100, 0, dst, 1);
    check("upstream drained", 1, ulog_at);
    ulat = 4'h1;
  endtask

  // Unclaimed completion is discarded after the timer; repeat starts anew
  task automatic s_discard();
    logic rt, dn, seen;
    bdto_res_t rs;
    int cyc;
    seen = 1'b0;
    cyc = 0;
    attempt(1, `BDTO_CMD_MEM_RD, 32'h4000, rt, dn, rs);
    check("discard first retry", 1, rt);
    // Drop only after the request was started, so it must survive
    @(negedge sys_clk_in);
    drop_req_in = 1'b1;
    @(negedge sys_clk_in);
    drop_req_in = 1'b0;
    for (cyc = 2; cyc < 80 && seen !== 1'b1; cyc++) begin
      @(negedge sys_clk_in);
      seen = discard_out;
    end
    check("discard seen", 1, seen);
    check("discard not early", 1, cyc > 16);
    txn(1, `BDTO_CMD_MEM_RD, 32'h4000, 0, dst, 1);
  endtask

  initial begin
    repeat (16) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    s_classify();
    s_order();
    s_pull();
    s_discard();
    final_report();
  end
endmodule
